/* rtl/vsc_clkgen.sv */
`default_nettype none
// Backplane clock from the board clock by a phase accumulator
module vsc_clkgen (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic run_i,
  output var  logic clk_o
);
  logic [7:0] acc_r, acc_nxt;  // Phase accumulator
  logic       clk_r, clk_nxt;  // Output level

  // 200 is not a multiple of 32, so edges jitter by one cycle; the mean is exact
  always_comb begin
    acc_nxt = acc_r;
    clk_nxt = clk_r;
    if (run_i) begin
      if (acc_r + vsc_pkg::CLK_ACC_STEP >= vsc_pkg::CLK_ACC_MOD) begin
        acc_nxt = 8'(acc_r + vsc_pkg::CLK_ACC_STEP - vsc_pkg::CLK_ACC_MOD);
        clk_nxt = ~clk_r;
      end else begin
        acc_nxt = 8'(acc_r + vsc_pkg::CLK_ACC_STEP);
      end
    end else begin
      // Parked low while stopped
      acc_nxt = 8'h00;
      clk_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 8'h00;
      clk_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign clk_o = clk_r;
endmodule
`default_nettype wire

/* rtl/vsc_pkg.sv */
`default_nettype none
package vsc_pkg;
  // Board clock and backplane clock rates
  localparam int MCLK_MHZ   = 200;
  localparam int SYSCLK_MHZ = 16;
  // Fractional divider: one toggle each time the accumulator wraps
  localparam logic [7:0] CLK_ACC_STEP = 8'(2 * SYSCLK_MHZ);
  localparam logic [7:0] CLK_ACC_MOD  = 8'(MCLK_MHZ);
  // Power-up probe window, least time, rounded up to whole cycles
  localparam int PROBE_NS  = 1000;
  localparam int PROBE_CYC = (PROBE_NS * MCLK_MHZ + 999) / 1000;
  localparam logic [7:0] PROBE_LAST = 8'(PROBE_CYC - 1);
  // Register map, word index taken from wb_adr_i[7:2]
  localparam logic [5:0] ADR_MISC = 6'h00;
  // Field positions of misc_control_register
  localparam int B_SW_EN     = 0;
  localparam int B_TMR_EN    = 1;
  localparam int B_SLOT1     = 8;
  localparam int B_PROBE_LOW = 9;
  localparam int B_DECIDED   = 10;
  localparam int B_AUTO_DIS  = 11;
  localparam int B_MANUAL    = 12;
  localparam int B_SYSCLK_ON = 13;
  localparam int B_UNDERV    = 14;
  localparam int B_ROLE      = 15;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] PIN_RST  = 4'h9;
  // Pin vector positions into the synchroniser
  localparam int P_BG3 = 0;
  localparam int P_AUTO_DIS = 1;
  localparam int P_MANUAL = 2;
  localparam int P_LV_N = 3;
  // Probe sequence
  typedef enum logic [0:0] {VSC_PROBE, VSC_DECIDED} vsc_state_t;
endpackage
`default_nettype wire

/* rtl/vsc_slot1_ctrl.sv */
// Behaviour
// (R1) Pull grant-in level 3 low at power-up
// (R2) Line held high elsewhere means not slot 1
// (R3) Automatic detection is the default
// (R4) Autodetect switch ON ignores probe result
// (R5) Manual switch selects slot 1 without autodetect
// (R6) Software may force system-controller role
// (R7) Slot-1 role enables the bus arbiter
// (R8) Slot-1 role drives grant levels 0 to 3
// (R9) Bus timer terminates cycles when enabled
// (R10) Backplane clock output is 16 MHz
// (R11) Clock enabled by probe, switch or software
// (R12) Clock runs until power loss or undervoltage
// (R13) Slot-1 status readable in control register
// (R14) Upstream boards drive grant-out level 3 high; here bgout_oe stays low until the controller role is set
// (R15) Decision latched after probe until reset
`default_nettype none
module vsc_slot1_ctrl (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Open-drain grant-in level 3 probe pin
  input  wire logic        bg3in_i,
  output var  logic        bg3in_o,
  output var  logic        bg3in_oe,
  // Board switches and supply monitor
  input  wire logic        autodetect_disable_switch,
  input  wire logic        manual_slot1_switch,
  input  wire logic        low_voltage_n,
  // On-board arbiter and bus timer, same clock
  input  wire logic [3:0]  arb_grant,
  input  wire logic        bus_timer_expired,
  // Backplane side
  output var  logic [3:0]  bgout_n_o,
  output var  logic [3:0]  bgout_oe,
  output var  logic        arbiter_enable,
  output var  logic        bus_timeout_term,
  output var  logic        sysclk_o,
  output var  logic        sysclk_oe
);

  // Synchronised pins
  logic [3:0] pin_lvl;
  logic       bg3_lvl, auto_dis, manual_on, underv;

  vsc_sync #(
    .W   (4),
    .RST (vsc_pkg::PIN_RST)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin_i ({low_voltage_n, manual_slot1_switch, autodetect_disable_switch, bg3in_i}),
    .lvl_o (pin_lvl)
  );

  assign bg3_lvl   = pin_lvl[vsc_pkg::P_BG3];
  assign auto_dis  = pin_lvl[vsc_pkg::P_AUTO_DIS];
  assign manual_on = pin_lvl[vsc_pkg::P_MANUAL];
  assign underv    = ~pin_lvl[vsc_pkg::P_LV_N];

  // Probe sequencer state
  vsc_pkg::vsc_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;          // Probe window counter
  logic       probe_low_r, probe_low_nxt; // Line was pulled low
  logic       slot1_r, slot1_nxt;      // Latched slot-1 decision
  logic       probe_oe_r, probe_oe_nxt; // Probe pin drive

  // Probe the line for a fixed window, then freeze the decision
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    probe_low_nxt = probe_low_r;
    slot1_nxt     = slot1_r;
    case (state_r)
      vsc_pkg::VSC_PROBE: begin
        if (cnt_r == vsc_pkg::PROBE_LAST) begin
          // Low level means nobody upstream drives it: slot 1
          probe_low_nxt = ~bg3_lvl;                       // R1 R2
          // Switch ON bypasses the probe, default uses it
          slot1_nxt = auto_dis ? manual_on : ~bg3_lvl;    // R3 R4 R5
          state_nxt = vsc_pkg::VSC_DECIDED;               // R15
        end else begin
          cnt_nxt = 8'(cnt_r + 8'h01);
        end
      end
      vsc_pkg::VSC_DECIDED: begin
        // Held until the next power-up reset
        state_nxt = vsc_pkg::VSC_DECIDED;                 // R15
      end
      default: state_nxt = vsc_pkg::VSC_PROBE;
    endcase
    // Drive low only while probing; released afterwards
    probe_oe_nxt = (state_nxt == vsc_pkg::VSC_PROBE);    // R1
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= vsc_pkg::VSC_PROBE;
      cnt_r       <= 8'h00;
      probe_low_r <= 1'b0;
      slot1_r     <= 1'b0;
      probe_oe_r  <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      probe_low_r <= probe_low_nxt;
      slot1_r     <= slot1_nxt;
      probe_oe_r  <= probe_oe_nxt;
    end
  end

  // Register bus
  logic [1:0]  ctrl_r, ctrl_nxt;   // Software enable and timer enable
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        req, hit;
  logic        role, decided;
  logic        sysclk_on_r, sysclk_on_nxt;

  assign req     = wb_cyc_i & wb_stb_i & ~ack_r;
  assign hit     = (wb_adr_i[7:2] == vsc_pkg::ADR_MISC);
  assign decided = (state_r == vsc_pkg::VSC_DECIDED);
  // Either the latched decision or software makes us controller
  assign role    = (decided & slot1_r) | ctrl_r[vsc_pkg::B_SW_EN]; // R6

  // One wait state: ack the cycle after the request, drop it after
  always_comb begin
    ack_nxt  = req;
    ctrl_nxt = ctrl_r;
    dat_nxt  = 32'h0000_0000;
    if (req && hit) begin
      if (wb_we_i) begin
        if (wb_sel_i[0]) begin
          ctrl_nxt = wb_dat_i[1:0];                     // R6
        end
      end else begin
        dat_nxt[vsc_pkg::B_SW_EN]     = ctrl_r[vsc_pkg::B_SW_EN];
        dat_nxt[vsc_pkg::B_TMR_EN]    = ctrl_r[vsc_pkg::B_TMR_EN];
        dat_nxt[vsc_pkg::B_SLOT1]     = slot1_r;        // R13
        dat_nxt[vsc_pkg::B_PROBE_LOW] = probe_low_r;    // R13
        dat_nxt[vsc_pkg::B_DECIDED]   = decided;
        dat_nxt[vsc_pkg::B_AUTO_DIS]  = auto_dis;
        dat_nxt[vsc_pkg::B_MANUAL]    = manual_on;
        dat_nxt[vsc_pkg::B_SYSCLK_ON] = sysclk_on_r;
        dat_nxt[vsc_pkg::B_UNDERV]    = underv;
        dat_nxt[vsc_pkg::B_ROLE]      = role;           // R13
      end
    end
    // Unmapped words read zero and ignore writes, but are still acked
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r  <= 1'b0;
      ctrl_r <= vsc_pkg::CTRL_RST;
      dat_r  <= 32'h0000_0000;
    end else begin
      ack_r  <= ack_nxt;
      ctrl_r <= ctrl_nxt;
      dat_r  <= dat_nxt;
    end
  end

  // System-controller duties
  logic       arb_en_r, arb_en_nxt;
  logic [3:0] bg_n_r, bg_n_nxt, bg_oe_r, bg_oe_nxt;
  logic       term_r, term_nxt;

  // Grant levels float unless the controller role (slot-1 decision or software) drives them
  always_comb begin
    arb_en_nxt = role;                                  // R7
    bg_oe_nxt  = {4{role}};                             // R8
    bg_n_nxt   = ~arb_grant;                            // R8
    // Timer only ends cycles as controller and when enabled
    term_nxt   = role & ctrl_r[vsc_pkg::B_TMR_EN] & bus_timer_expired; // R9
    // Sticky once on; only undervoltage stops it
    if (underv) begin
      sysclk_on_nxt = 1'b0;                             // R12
    end else begin
      sysclk_on_nxt = sysclk_on_r | role;               // R11 R12
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arb_en_r    <= 1'b0;
      bg_oe_r     <= 4'h0;
      bg_n_r      <= 4'hf;
      term_r      <= 1'b0;
      sysclk_on_r <= 1'b0;
    end else begin
      arb_en_r    <= arb_en_nxt;
      bg_oe_r     <= bg_oe_nxt;
      bg_n_r      <= bg_n_nxt;
      term_r      <= term_nxt;
      sysclk_on_r <= sysclk_on_nxt;
    end
  end

  // Clock divider runs only while the driver is on
  vsc_clkgen u_clk (
    .mclk  (mclk),
    .rst_n (rst_n),
    .run_i (sysclk_on_r),                               // R10
    .clk_o (sysclk_o)
  );

  assign wb_ack_o         = ack_r;
  assign wb_dat_o         = dat_r;
  assign bg3in_o          = 1'b0;
  assign bg3in_oe         = probe_oe_r;
  assign bgout_n_o        = bg_n_r;
  assign bgout_oe         = bg_oe_r;
  assign arbiter_enable   = arb_en_r;
  assign bus_timeout_term = term_r;
  assign sysclk_oe        = sysclk_on_r;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_probe_drive;
    (state_r == vsc_pkg::VSC_PROBE) && $past(rst_n) |-> bg3in_oe && !bg3in_o;
  endproperty
  a_probe_drive: assert property (p_probe_drive) else $error("probe not driving low"); // R1

  property p_probe_auto;
    $rose(decided) && !$past(auto_dis) |-> slot1_r == !$past(bg3_lvl) && !bg3in_oe;
  endproperty
  a_probe_auto: assert property (p_probe_auto) else $error("probe result not used"); // R2

  property p_manual;
    $rose(decided) && $past(auto_dis) |-> slot1_r == $past(manual_on);
  endproperty
  a_manual: assert property (p_manual) else $error("manual switch not used"); // R5

  property p_latched;
    decided && $past(decided) |-> $stable(slot1_r) && $stable(probe_low_r);
  endproperty
  a_latched: assert property (p_latched) else $error("decision changed"); // R15

  property p_arbiter;
    (decided && slot1_r) || ctrl_r[vsc_pkg::B_SW_EN] |=> arbiter_enable && bgout_oe == 4'hf;
  endproperty
  a_arbiter: assert property (p_arbiter) else $error("controller duties off"); // R7

  property p_no_grant_drive;
    !role |=> bgout_oe == 4'h0 && !arbiter_enable;
  endproperty
  a_no_grant_drive: assert property (p_no_grant_drive) else $error("grants driven"); // R8

  // Grant levels follow the on-board arbiter one edge late
  property p_grant_follow;
    role |=> bgout_n_o == ~$past(arb_grant);
  endproperty
  a_grant_follow: assert property (p_grant_follow) else $error("grant levels wrong"); // R8

  property p_term;
    bus_timeout_term |-> $past(role && ctrl_r[vsc_pkg::B_TMR_EN] && bus_timer_expired);
  endproperty
  a_term: assert property (p_term) else $error("timeout without cause"); // R9

  // A qualified expiry always ends the cycle on the next edge
  property p_term_fires;
    role && ctrl_r[vsc_pkg::B_TMR_EN] && bus_timer_expired |=> bus_timeout_term;
  endproperty
  a_term_fires: assert property (p_term_fires) else $error("timeout not terminated"); // R9

  // A driver switched off parks the clock low, which ends the check rather than failing it
  property p_clock_runs;
    sysclk_oe && $past(sysclk_oe) && !underv |-> ##[1:7] ($changed(sysclk_o) || !sysclk_oe);
  endproperty
  a_clock_runs: assert property (p_clock_runs) else $error("backplane clock stuck"); // R10

  property p_clock_sticky;
    sysclk_oe && !underv |=> sysclk_oe;
  endproperty
  a_clock_sticky: assert property (p_clock_sticky) else $error("clock dropped"); // R12

  property p_clock_on;
    role && !underv |=> sysclk_oe;
  endproperty
  a_clock_on: assert property (p_clock_on) else $error("clock not enabled"); // R11

  property p_status_read;
    wb_ack_o && $past(!wb_we_i && hit) |-> wb_dat_o[vsc_pkg::B_SLOT1] == $past(slot1_r);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status misread"); // R13

  c_slot1_found: cover property ($rose(decided) && slot1_r);
  c_not_slot1:   cover property ($rose(decided) && !slot1_r);
  c_sw_role:     cover property ($rose(ctrl_r[vsc_pkg::B_SW_EN]) && !slot1_r);
  c_term:        cover property (bus_timeout_term);
  c_clock_on:    cover property ($rose(sysclk_oe));
endmodule
`default_nettype wire

/* rtl/vsc_sync.sv */
`default_nettype none
// Three-stage pin synchroniser; output moves once stages two and three agree
module vsc_sync #(
  parameter int               W   = 4,
  parameter logic [W-1:0]     RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_i,
  output var  logic [W-1:0] lvl_o
);
  logic [W-1:0] s1_r, s2_r, s3_r;   // Metastability chain
  logic [W-1:0] lvl_r, lvl_nxt;     // Filtered level

  // Accept a new level only when both late stages hold it
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
    end
  end

  // Stage one feeds only stage two
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r  <= RST;
      s2_r  <= RST;
      s3_r  <= RST;
      lvl_r <= RST;
    end else begin
      s1_r  <= pin_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign lvl_o = lvl_r;
endmodule
`default_nettype wire

/* tb/vme_slot1_system_controller_tb.sv */
`default_nettype none
module vme_slot1_system_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;  // Board clock, 200 MHz
  logic        rst_n = 1'b0; // Power-up reset
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        bg3_line, bg3in_o, bg3in_oe;
  logic        upstream = 1'b0; // Selects slot 1 or a later slot
  logic        autodetect_disable_switch = 1'b0;
  logic        manual_slot1_switch = 1'b0;
  logic        low_voltage_n = 1'b1;
  logic [3:0]  arb_grant = 4'h0;
  logic        bus_timer_expired = 1'b0;
  logic [3:0]  bgout_n_o, bgout_oe;
  logic        arbiter_enable, bus_timeout_term, sysclk_o, sysclk_oe;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc_cnt = 0; // Hang guard
  int          n;
  logic        prev;
  logic [31:0] rd;          // Last read word
  logic [3:0]  sel_use = 4'hf; // Byte lanes for the next access

  always #2.5 mclk = ~mclk;

  vsc_slot1_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bg3in_i(bg3_line), .bg3in_o(bg3in_o),
    .bg3in_oe(bg3in_oe), .autodetect_disable_switch(autodetect_disable_switch),
    .manual_slot1_switch(manual_slot1_switch), .low_voltage_n(low_voltage_n),
    .arb_grant(arb_grant), .bus_timer_expired(bus_timer_expired), .bgout_n_o(bgout_n_o),
    .bgout_oe(bgout_oe), .arbiter_enable(arbiter_enable), .bus_timeout_term(bus_timeout_term),
    .sysclk_o(sysclk_o), .sysclk_oe(sysclk_oe));

  vsc_bp_model bp_u (.bg3in_o(bg3in_o), .bg3in_oe(bg3in_oe), .upstream(upstream), .bg3_line(bg3_line));

  // Verdict and end of run
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run needs well under two thousand cycles
  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; ack and read data are taken at the same rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel_use;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // Power-up with given backplane and switch setup, past the probe window
  task automatic boot(input logic up, input logic ad, input logic man);
    @(posedge mclk);
    rst_n <= 1'b0;
    upstream <= up;
    autodetect_disable_switch <= ad;
    manual_slot1_switch <= man;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(bg3in_oe, 1'b0);
    @(negedge mclk);
    chk(bg3in_oe, 1'b1);
    chk(bg3in_o, 1'b0);
    repeat (210) @(posedge mclk);
  endtask

  // Controller role as seen in status and at the backplane drivers
  task automatic role_chk(input logic exp);
    wb(1'b0, 8'h00, 32'h0);
    @(negedge mclk);
    chk(rd[vsc_pkg::B_ROLE], exp);
    chk(arbiter_enable, exp);
    chk(bgout_oe, {4{exp}});
    chk(sysclk_oe, exp);
    chk(bg3in_oe, 1'b0);
  endtask

  // One timer expiry with a grant pattern alongside
  task automatic pulse(input logic exp);
    @(posedge mclk);
    bus_timer_expired <= 1'b1;
    arb_grant <= 4'h5;
    @(posedge mclk);
    bus_timer_expired <= 1'b0;
    @(negedge mclk);
    chk(bus_timeout_term, exp);
    @(negedge mclk);
    chk(bus_timeout_term, 1'b0);
  endtask

  initial begin
    // Slot 1, default switches
    boot(1'b0, 1'b0, 1'b0);
    role_chk(1'b1);
    chk(rd[vsc_pkg::B_SLOT1], 1'b1);
    chk(rd[vsc_pkg::B_PROBE_LOW], 1'b1);
    chk(rd[vsc_pkg::B_DECIDED], 1'b1);
    n = 0;
    prev = sysclk_o;
    repeat (250) begin
      @(negedge mclk);
      if (sysclk_o === 1'b1 && prev === 1'b0) n++;
      prev = sysclk_o;
    end
    chk(n >= 19 && n <= 21, 1'b1);
    wb(1'b1, 8'h00, 32'h2);
    pulse(1'b1);
    chk(bgout_n_o, 4'ha);
    // Switches moved after the decision stay readable but change nothing
    @(posedge mclk);
    autodetect_disable_switch <= 1'b1;
    repeat (8) @(posedge mclk);
    role_chk(1'b1);
    chk(rd[vsc_pkg::B_AUTO_DIS], 1'b1);
    chk(rd[vsc_pkg::B_SLOT1], 1'b1);
    // Undervoltage stops the clock driver
    @(posedge mclk);
    low_voltage_n <= 1'b0;
    repeat (10) @(negedge mclk);
    chk(sysclk_oe, 1'b0);
    chk(sysclk_o, 1'b0);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd[vsc_pkg::B_UNDERV], 1'b1);
    low_voltage_n <= 1'b1;
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    // Later slot: probe fails, then software takes the role
    boot(1'b1, 1'b0, 1'b0);
    role_chk(1'b0);
    chk(rd[vsc_pkg::B_PROBE_LOW], 1'b0);
    wb(1'b1, 8'h00, 32'h2);
    pulse(1'b0);
    wb(1'b1, 8'h00, 32'h3);
    role_chk(1'b1);
    // A write without the low byte lane leaves the enables alone
    sel_use = 4'he;
    wb(1'b1, 8'h00, 32'h0);
    sel_use = 4'hf;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd[1:0], 2'h3);
    // Manual selection overrides the probe either way
    boot(1'b1, 1'b1, 1'b1);
    role_chk(1'b1);
    boot(1'b0, 1'b1, 1'b0);
    role_chk(1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire

/* tb/vsc_bp_model.sv */
`default_nettype none
// Backplane behind the grant-in level 3 pin: pull-up plus optional upstream board
module vsc_bp_model (
  input  wire logic bg3in_o,  // Device drive value
  input  wire logic bg3in_oe, // Device pulls while high
  input  wire logic upstream, // A higher-priority board is present
  output var  logic bg3_line  // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A compliant upstream board wins over the pull, so the probe fails
  always_comb begin
    if (upstream) begin
      bg3_line = 1'b1;
    end else if (bg3in_oe) begin
      bg3_line = bg3in_o; // Floating slot-1 line follows the pull
    end else begin
      bg3_line = 1'b1; // Pull-up once released
    end
  end
endmodule
`default_nettype wire
